// >>> adc_ctrl_pkg.sv
// shared constants and types for the converter control block
package adc_ctrl_pkg;
  localparam int CORE_CLK_HZ = 200_000_000;
  localparam int OUT_BITS = 32;
  localparam int IN_BITS = 8;
  localparam int CTRL_BITS = 3;
  localparam int ADDR_BITS = 5;
  localparam int CNT_W = 6;
  localparam logic [CTRL_BITS-1:0] CTRL_UPDATE = 3'h5;
  localparam logic [CTRL_BITS-1:0] CTRL_KEEP = 3'h4;
  localparam logic [CTRL_BITS-1:0] CTRL_KEEP_GND = 3'h0;
  localparam logic [ADDR_BITS-1:0] ADDR_RESET = 5'h00;
  localparam logic [CNT_W-1:0] OUT_BITS_CNT = 6'h20;
  localparam logic [CNT_W-1:0] IN_BITS_CNT = 6'h08;
  // internal serial clock rate and its half period in core cycles
  localparam int ISCK_HZ = 19_200;
  localparam int ISCK_HALF_CYC = CORE_CLK_HZ / (2 * ISCK_HZ);
  // slowest external notch clock is 2.56 kHz; window spans one period
  localparam int EXT_OSC_MIN_HZ = 2_560;
  localparam int EXT_WINDOW_CYC = (CORE_CLK_HZ + EXT_OSC_MIN_HZ - 1) / EXT_OSC_MIN_HZ;
  localparam int NULL_DIVIDE = 2560;
  typedef enum logic [1:0] {NOTCH_60HZ, NOTCH_50HZ, NOTCH_EXT} notch_mode_t;
endpackage

// >>> shift_if.sv
// carrier between the cycle control and the serial shifter
`timescale 1ns/1ps
interface shift_if;
  import adc_ctrl_pkg::*;
  logic load;
  logic [OUT_BITS-1:0] loadWord;
  logic rise;
  logic fall;
  logic outBit;
  logic inBit;
  logic [IN_BITS-1:0] inWord;
  logic [CNT_W-1:0] riseCount;
  modport ctrl (output load, loadWord, rise, fall, inBit, input outBit, inWord, riseCount);
  modport shifter (input load, loadWord, rise, fall, inBit, output outBit, inWord, riseCount);
endinterface

// >>> serial_shifter.sv
// static output shift register and input word capture
`timescale 1ns/1ps
module serial_shifter
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // control side
  shift_if.shifter sh
);
  logic [OUT_BITS-1:0] outReg_q;
  logic [IN_BITS-1:0] inReg_q;
  logic [CNT_W-1:0] count_q;
  logic armed_q;

  assign sh.outBit = outReg_q[OUT_BITS-1];
  assign sh.inWord = inReg_q;
  assign sh.riseCount = count_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outReg_q <= '0;
      inReg_q <= '0;
      count_q <= '0;
      armed_q <= 1'b0;
    end else if (sh.load) begin
      // result held here untouched through sleep
      outReg_q <= sh.loadWord;
      inReg_q <= '0;
      count_q <= '0;
      armed_q <= 1'b0;
    end else begin
      if (sh.rise && count_q < OUT_BITS_CNT) begin
        count_q <= count_q + 6'h01;
        armed_q <= 1'b1;
        if (count_q < IN_BITS_CNT) begin
          inReg_q <= {inReg_q[IN_BITS-2:0], sh.inBit};
        end
      end
      if (sh.fall && armed_q) begin
        outReg_q <= {outReg_q[OUT_BITS-2:0], 1'b0};
        armed_q <= 1'b0;
      end
    end
  end
endmodule

// >>> notch_clock_detect.sv
// picks the notch frequency source from the frequency-control pin
`timescale 1ns/1ps
module notch_clock_detect
  import adc_ctrl_pkg::*;
#(
  parameter int WINDOW_CYC = EXT_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // synchronised pin level
  input wire logic pinSync,
  // results
  output notch_mode_t mode,
  output logic nullTick
);
  initial begin
    if (WINDOW_CYC < 2) $error("WINDOW_CYC too small");
  end
  logic pinLast_q;
  logic [31:0] quiet_q;
  logic [11:0] div_q;
  logic extSeen_q;
  notch_mode_t mode_q;
  logic tick_q;
  wire pinRise = pinSync & ~pinLast_q;
  wire pinEdge = pinSync ^ pinLast_q;
  wire divWrap = (div_q == 12'(NULL_DIVIDE - 1));

  assign mode = mode_q;
  assign nullTick = tick_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinLast_q <= 1'b0;
      quiet_q <= '0;
      extSeen_q <= 1'b0;
    end else begin
      pinLast_q <= pinSync;
      quiet_q <= pinEdge ? '0 : (quiet_q < 32'(WINDOW_CYC) ? quiet_q + 32'h1 : quiet_q);
      extSeen_q <= pinEdge ? 1'b1 : (quiet_q >= 32'(WINDOW_CYC) ? 1'b0 : extSeen_q);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mode_q <= NOTCH_60HZ;
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      mode_q <= extSeen_q ? NOTCH_EXT : (pinSync ? NOTCH_50HZ : NOTCH_60HZ);
      tick_q <= extSeen_q && pinRise && divWrap;
      if (pinRise) begin
        div_q <= divWrap ? 12'h000 : div_q + 12'h001;
      end
    end
  end
endmodule

// >>> adc_cycle_serial_control.sv
// conversion, sleep and serial data transfer cycle control
// Functional notes
// - convert, sleep, data transfer, repeat
// - sleep after conversion while select high
// - result held in shifter during sleep
// - select low wakes, drives output, enters transfer
// - data output released while select high
// - output shows busy status before transfer
// - select high before first rise: sleep
// - after first rise shift out and in
// - select high mid-transfer starts conversion
// - output changes on falling serial clock
// - transfer ends after 32 bits
// - input ignored outside transfer
// - channel updates at once, next conversion
// - internal mode drives clock, weak pull-up
// - clock mode sampled at reset, select fall
// - level on notch pin picks 50/60
// - external notch clock divided by 2560
// - eight bits: three control, five address
// - load address only on 101
// - first conversion uses address zero
`timescale 1ns/1ps
module adc_cycle_serial_control
  import adc_ctrl_pkg::*;
#(
  parameter int ISCK_HALF = ISCK_HALF_CYC,
  parameter int EXT_WINDOW = EXT_WINDOW_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial port pins
  input wire logic csN,
  input wire logic sdi,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOeN,
  output logic sckPullupEn,
  output logic sdoOut,
  output logic sdoOeN,
  // frequency-control pin
  input wire logic notchClockSelect,
  // analog converter side
  output logic convStart,
  input wire logic convDone,
  input wire logic [OUT_BITS-1:0] convWord,
  output logic [ADDR_BITS-1:0] chanAddr,
  output logic singleEndedSelect,
  // status
  output notch_mode_t notchMode,
  output logic nullTick,
  output logic extSckMode,
  output logic asleep
);
  initial begin
    if (ISCK_HALF < 2) $error("ISCK_HALF too small");
    if (ISCK_HALF > 65536) $error("ISCK_HALF too large");
    if (EXT_WINDOW < 2) $error("EXT_WINDOW too small");
  end

  typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_WAIT_RISE, ST_SHIFT} state_t;

  // reset release
  logic rstMeta_q;
  logic rstN;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end

  // pin synchronisers
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic csLast_q;
  logic sckLast_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= 4'hF;
      sync_q <= 4'hF;
      csLast_q <= 1'b1;
      sckLast_q <= 1'b1;
    end else begin
      meta_q <= {notchClockSelect, sckIn, sdi, csN};
      sync_q <= meta_q;
      csLast_q <= sync_q[0];
      sckLast_q <= sync_q[2];
    end
  end
  wire csSync = sync_q[0];
  wire sdiSync = sync_q[1];
  wire sckSync = sync_q[2];
  wire notchSync = sync_q[3];
  wire csFall = csLast_q & ~csSync;

  state_t state_q;
  state_t state_d;
  logic extMode_q;
  logic [1:0] modeArm_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic addrDone_q;
  logic convStart_q;
  logic iSck_q;
  logic [15:0] iDiv_q;
  logic sdo_q;
  logic sdoOeN_q;
  logic sckOeN_q;

  shift_if sh ();

  serial_shifter u_shift (
    .clk (core_clk),
    .rstN (rstN),
    .sh (sh.shifter)
  );

  notch_clock_detect #(
    .WINDOW_CYC (EXT_WINDOW)
  ) u_notch (
    .clk (core_clk),
    .rstN (rstN),
    .pinSync (notchSync),
    .mode (notchMode),
    .nullTick (nullTick)
  );

  // serial clock edges from pin or own divider
  wire inTransfer = (state_q == ST_WAIT_RISE) || (state_q == ST_SHIFT);
  wire iHalfDone = (iDiv_q == 16'(ISCK_HALF - 1));
  wire iRise = !extMode_q && inTransfer && iHalfDone && !iSck_q;
  wire iFall = !extMode_q && inTransfer && iHalfDone && iSck_q;
  wire eRise = extMode_q && sckSync && !sckLast_q;
  wire eFall = extMode_q && !sckSync && sckLast_q;
  wire sckRise = inTransfer && !csSync && (eRise || iRise);
  wire sckFall = inTransfer && !csSync && (eFall || iFall);
  wire allOut = (sh.riseCount == OUT_BITS_CNT);

  assign sh.rise = sckRise;
  assign sh.fall = sckFall;
  assign sh.inBit = sdiSync;
  assign sh.load = convDone && (state_q == ST_CONVERT);
  assign sh.loadWord = convWord;

  // cycle state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CONVERT: begin
        if (convDone) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!csSync) begin
          state_d = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        if (csSync) begin
          state_d = ST_SLEEP;
        end else if (sckRise) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (csSync || allOut) begin
          state_d = ST_CONVERT;
        end
      end
      default: begin
        state_d = ST_CONVERT;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_CONVERT;
      convStart_q <= 1'b1;
    end else begin
      state_q <= state_d;
      convStart_q <= (state_d == ST_CONVERT) && (state_q != ST_CONVERT);
    end
  end

  // power-up sample waits until the pin level has crossed the synchroniser
  wire modeArmed = (modeArm_q == 2'h1);
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      extMode_q <= 1'b0;
      modeArm_q <= 2'h3;
    end else begin
      if (modeArm_q != 2'h0) begin
        modeArm_q <= modeArm_q - 2'h1;
      end
      if (modeArmed || (csFall && !inTransfer)) begin
        extMode_q <= !sckSync;
      end
    end
  end

  // internal serial clock divider, low first after select falls
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      iSck_q <= 1'b1;
      iDiv_q <= '0;
    end else if (!inTransfer || extMode_q) begin
      iSck_q <= 1'b1;
      iDiv_q <= '0;
    end else if (state_q == ST_WAIT_RISE && iSck_q) begin
      iSck_q <= 1'b0;
      iDiv_q <= '0;
    end else begin
      iDiv_q <= iHalfDone ? 16'h0000 : iDiv_q + 16'h0001;
      if (iHalfDone) begin
        iSck_q <= !iSck_q;
      end
    end
  end

  // channel address; reset default
  wire [CTRL_BITS-1:0] ctrlBits = sh.inWord[IN_BITS-1 -: CTRL_BITS];
  wire inWordReady = (sh.riseCount == IN_BITS_CNT) && (state_q == ST_SHIFT);
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      addr_q <= ADDR_RESET;
      addrDone_q <= 1'b0;
    end else begin
      if (state_q != ST_SHIFT) begin
        addrDone_q <= 1'b0;
      end else if (inWordReady && !addrDone_q) begin
        addrDone_q <= 1'b1;
        if (ctrlBits == CTRL_UPDATE) begin
          addr_q <= sh.inWord[ADDR_BITS-1:0];
        end
      end
    end
  end

  // pin drivers
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sdo_q <= 1'b1;
      sdoOeN_q <= 1'b1;
      sckOeN_q <= 1'b1;
    end else begin
      sdoOeN_q <= csSync;
      sdo_q <= (state_q == ST_CONVERT) ? 1'b1 : sh.outBit;
      sckOeN_q <= !(inTransfer && !extMode_q && !csSync);
    end
  end

  // shifter keeps result through sleep until shifted out
  assign sdoOut = sdo_q;
  assign sdoOeN = sdoOeN_q;
  assign sckOut = iSck_q;
  assign sckOeN = sckOeN_q;
  assign sckPullupEn = !extMode_q;
  assign convStart = convStart_q;
  assign chanAddr = addr_q;
  assign singleEndedSelect = addr_q[ADDR_BITS-1];
  assign extSckMode = extMode_q;
  assign asleep = (state_q == ST_SLEEP);
endmodule

// >>> adc_ctrl_asserts.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
module adc_ctrl_asserts
  import adc_ctrl_pkg::*;
#(
  parameter int ISCK_HALF = 8,
  parameter int EXT_WINDOW = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial pins
  input wire logic csN,
  input wire logic sckIn,
  input wire logic sckOeN,
  input wire logic sckPullupEn,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  // converter and status
  input wire logic convStart,
  input wire logic convDone,
  input wire logic [ADDR_BITS-1:0] chanAddr,
  input wire logic extSckMode,
  input wire logic asleep
);
  logic busy_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // conversion running, from start pulse to done
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) busy_q <= 1'b1;
    else busy_q <= convStart | (busy_q & ~convDone);
  AST_SDO_OFF: assert property (csN [*4] |-> sdoOeN) else $error("sdo driven while deselected");
  AST_SDO_ON: assert property ((!csN) [*4] |-> !sdoOeN) else $error("sdo idle while selected");
  AST_SLEEP: assert property (busy_q && convDone |=> asleep) else $error("no sleep after conversion");
  AST_STAY: assert property (csN [*6] ##0 asleep |=> asleep) else $error("woke while deselected");
  AST_BUSY: assert property (busy_q && $past(busy_q) && !sdoOeN |-> sdoOut) else $error("status not busy");
  AST_SCK: assert property (!sckOeN |-> sckPullupEn && !extSckMode) else $error("clock driven wrongly");
  AST_MODE: assert property ($fell(csN) |-> ##5 extSckMode == !$past(sckIn, 5)) else $error("wrong clock mode");
  AST_ADDR: assert property (!$stable(chanAddr) |-> !asleep && !busy_q) else $error("address moved idle");
  AST_START: assert property ($rose(convStart) |=> !convStart) else $error("start pulse too long");
endmodule
bind adc_cycle_serial_control adc_ctrl_asserts #(.ISCK_HALF(ISCK_HALF), .EXT_WINDOW(EXT_WINDOW)) chk (.*);

// >>> host_serial_model.sv
// host controller model on the four-wire serial port
`timescale 1ns/1ps
module host_serial_model
  import adc_ctrl_pkg::*;
(
  // device side
  input wire logic core_clk,
  input wire logic sckOut,
  input wire logic sckOeN,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  // host drive
  output logic csN,
  output logic sdi,
  output logic sckIn
);
  logic sckDrive = 1'b1;
  logic sckHost = 1'b1;
  logic [IN_BITS-1:0] txWord = '0;
  logic [OUT_BITS-1:0] rxWord = '0;
  int rises = 0;
  initial csN = 1'b1;
  initial sdi = 1'b0;
  assign sckIn = !sckOeN ? sckOut : (sckDrive ? sckHost : 1'b1);
  // capture on rise, released sdo reads inverted
  always @(posedge sckIn) begin
    if (!csN) begin
      rxWord <= {rxWord[OUT_BITS-2:0], sdoOut ^ sdoOeN};
      rises <= rises + 1;
    end
  end
  always @(negedge sckIn) begin
    if (!csN) begin
      sdi <= (rises < IN_BITS) ? txWord[IN_BITS-1-rises] : ~sdi;
    end
  end
  // clock level set before select falls
  task automatic open_frame(input logic ext, input logic [IN_BITS-1:0] tx);
    sckDrive = ext;
    sckHost = 1'b0;
    txWord = tx;
    sdi = tx[IN_BITS-1];
    rises = 0;
    repeat (12) @(posedge core_clk);
    #1 csN = 1'b0;
  endtask
  task automatic clock_bits(input int n);
    repeat (n) begin
      repeat (10) @(posedge core_clk);
      #1 sckHost = 1'b1;
      repeat (10) @(posedge core_clk);
      #1 sckHost = 1'b0;
    end
  endtask
  task automatic close_frame();
    repeat (10) @(posedge core_clk);
    #1 csN = 1'b1;
    sckDrive = 1'b1;
    sckHost = 1'b1;
  endtask
endmodule

// >>> adc_cycle_serial_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_cycle_serial_control_tb_top;
  import adc_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic notchClockSelect = 1'b0;
  logic convDone = 1'b0;
  logic [OUT_BITS-1:0] convWord = '0;
  logic csN, sdi, sckIn, sckOut, sckOeN, sckPullupEn, sdoOut, sdoOeN;
  logic convStart, singleEndedSelect, extSckMode, asleep, nullTick;
  logic [ADDR_BITS-1:0] chanAddr;
  notch_mode_t notchMode;
  int miscompares = 0;
  int totalChecks = 0;
  int starts = 0;
  int ticks = 0;
  int startsSeen = 0;
  logic [OUT_BITS-1:0] words [3] = '{32'h5A3C_96F0, 32'h0F1E_2D3C, 32'hC001_7FFE};
  logic [IN_BITS-1:0] codes [3] = '{{CTRL_KEEP, 5'h0A}, {CTRL_KEEP_GND, 5'h1F}, {CTRL_UPDATE, 5'h06}};
  logic [ADDR_BITS-1:0] addrs [3] = '{5'h13, 5'h13, 5'h06};
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    starts <= starts + int'(convStart);
    ticks <= ticks + int'(nullTick);
  end
  adc_cycle_serial_control #(.ISCK_HALF(8), .EXT_WINDOW(50)) uut (.*);
  host_serial_model host (.*);
  task automatic check(input logic [OUT_BITS-1:0] got, input logic [OUT_BITS-1:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // finish the running conversion with a result
  task automatic convert(input logic [OUT_BITS-1:0] w);
    repeat (20) @(posedge core_clk);
    #1 convWord = w;
    convDone = 1'b1;
    @(posedge core_clk);
    #1 convDone = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check(asleep, 1'b1);
  endtask
  task automatic frame(input logic ext, input logic [IN_BITS-1:0] tx, input int n);
    host.open_frame(ext, tx);
    if (ext) begin
      host.clock_bits(n);
    end else begin
      for (int i = 0; i < 2000 && host.rises < n; i++) @(posedge core_clk);
    end
    if (host.rises != n) begin
      miscompares++;
      summarize();
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check(chanAddr, ADDR_RESET);
    convert(32'h25C3_1E69);
    startsSeen = starts;
    host.open_frame(1'b1, 8'h00);
    repeat (8) @(posedge core_clk);
    #1 check(sdoOeN, 1'b0);
    check(sdoOut, 1'b0);
    check(asleep, 1'b0);
    host.close_frame();
    repeat (8) @(posedge core_clk);
    #1 check(asleep, 1'b1);
    check(sdoOeN, 1'b1);
    check(starts, startsSeen);
    frame(1'b1, {CTRL_UPDATE, 5'h13}, OUT_BITS);
    repeat (6) @(posedge core_clk);
    #1 check(sdoOut, 1'b1);
    check(host.rxWord, 32'h25C3_1E69);
    check(chanAddr, 5'h13);
    check(singleEndedSelect, 1'b1);
    check(extSckMode, 1'b1);
    check(starts, startsSeen + 1);
    host.close_frame();
    $display("cycle test done");
    for (int i = 0; i < 3; i++) begin
      convert(words[i]);
      frame(1'b1, codes[i], OUT_BITS);
      #1 check(host.rxWord, words[i]);
      check(chanAddr, addrs[i]);
      host.close_frame();
    end
    $display("code test done");
    convert(32'h8000_0001);
    startsSeen = starts;
    frame(1'b1, {CTRL_UPDATE, 5'h01}, 5);
    host.close_frame();
    repeat (8) @(posedge core_clk);
    #1 check(starts, startsSeen + 1);
    check(asleep, 1'b0);
    check(chanAddr, 5'h06);
    $display("abort test done");
    convert(32'h3CA5_5AC3);
    frame(1'b0, {CTRL_UPDATE, 5'h1C}, OUT_BITS);
    repeat (6) @(posedge core_clk);
    #1 check(extSckMode, 1'b0);
    check(sckPullupEn, 1'b1);
    check(host.rxWord, 32'h3CA5_5AC3);
    check(chanAddr, 5'h1C);
    host.close_frame();
    $display("internal clock test done");
    notchClockSelect = 1'b1;
    repeat (200) @(posedge core_clk);
    #1 check(notchMode, NOTCH_50HZ);
    notchClockSelect = 1'b0;
    repeat (200) @(posedge core_clk);
    #1 check(notchMode, NOTCH_60HZ);
    ticks = 0;
    repeat (10400) begin
      repeat (3) @(posedge core_clk);
      #1 notchClockSelect = ~notchClockSelect;
    end
    check(notchMode, NOTCH_EXT);
    check(ticks, 2);
    $display("notch test done");
    summarize();
  end
endmodule
